// >>> sim/gpbk_board.sv
// baseboard model for the gpio bank pins
// assumes the bench sets ext_level for pins that the bank leaves as inputs
`timescale 1ns/1ps

module gpbk_board
  import gpbk_pkg::*;
(
  // bank side
  input  wire logic [31:0] gpio_out,
  input  wire logic [31:0] gpio_oe_n,
  // bench side
  input  wire logic [31:0] ext_level,
  // pin level seen by the bank
  output logic      [31:0] gpio_in
);
  // ----------------------------------------------------------------
  // pin wire: driven pins loop back, the rest follow the board
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      gpio_in[i] = gpio_oe_n[i] ? ext_level[i] : gpio_out[i];
    end
  end
endmodule : gpbk_board

// >>> sim/tb.sv
// self-checking bench for the gpio bank, apb master plus board model
// assumes gpbk_cfg.svh on the include path and a 10 MHz pclk
`timescale 1ns/1ps
`include "gpbk_cfg.svh"

module tb;
  import gpbk_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  gpbk_addr_t paddr;
  gpbk_word_t pwdata, prdata, gpio_in, gpio_out, gpio_oe_n, ext_level;
  int         n_fail, checks_done;

  gpbk_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .irq(irq));
  gpbk_board board (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .ext_level(ext_level), .gpio_in(gpio_in));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input gpbk_word_t got, input gpbk_word_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // apb master: setup, access until pready, release
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input gpbk_addr_t a, input gpbk_word_t d,
                     output gpbk_word_t rdat, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the wait ends at pready; only the watchdog ends it if pready never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let the write edge settle before callers look at the pins
    @(negedge pclk);
  endtask : apb

  task automatic wr(input gpbk_addr_t a, input gpbk_word_t d);
    gpbk_word_t r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input gpbk_addr_t a, input gpbk_word_t exp);
    gpbk_word_t r;
    logic       e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask : rd

  task automatic pins(input gpbk_word_t v);
    @(posedge pclk);
    ext_level <= v;
    repeat (4) @(posedge pclk);
  endtask : pins

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge pclk);
    n_fail++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // tests; software touches only bits 26..16
  // ----------------------------------------------------------------
  initial begin : main
    gpbk_word_t r;
    logic       e;
    n_fail = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_level = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(gpio_oe_n, 32'hFFFF_FFFF);
    chk(gpio_out, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(`GPBK_OFF_DIR, 32'h0000_0000);
    rd(`GPBK_OFF_RISE, 32'h0000_0000);
    rd(`GPBK_OFF_FALL, 32'h0000_0000);
    rd(`GPBK_OFF_STS, 32'h0000_0000);
    rd(`GPBK_OFF_MASK, 32'h0000_0000);
    $display("test reset done");

    wr(`GPBK_OFF_SET, 32'h07FF_0000);
    chk(gpio_out, 32'h07FF_0000);
    chk(gpio_oe_n, 32'hFFFF_FFFF);
    rd(`GPBK_OFF_LEVEL, 32'h0000_0000);
    wr(`GPBK_OFF_CLR, 32'h0003_0000);
    chk(gpio_out, 32'h07FC_0000);
    wr(`GPBK_OFF_DIR, 32'h07FF_0000);
    rd(`GPBK_OFF_DIR, 32'h07FF_0000);
    chk(gpio_oe_n, 32'hF800_FFFF);
    repeat (4) @(posedge pclk);
    rd(`GPBK_OFF_LEVEL, 32'h07FC_0000);
    wr(`GPBK_OFF_CLR, 32'h07FF_0000);
    wr(`GPBK_OFF_DIR, 32'h0000_0000);
    chk(gpio_oe_n, 32'hFFFF_FFFF);
    $display("test outputs done");

    apb(1'b1, 12'h100, 32'h07FF_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, 12'h100, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    rd(`GPBK_OFF_SET, 32'h0000_0000);
    $display("test unmapped done");

    wr(`GPBK_OFF_RISE, 32'h0005_0000);
    wr(`GPBK_OFF_FALL, 32'h0006_0000);
    pins(32'h0007_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(`GPBK_OFF_STS, 32'h0005_0000);
    wr(`GPBK_OFF_MASK, 32'h0007_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`GPBK_OFF_STS, 32'h0001_0000);
    rd(`GPBK_OFF_STS, 32'h0004_0000);
    wr(`GPBK_OFF_STS, 32'h0000_0000);
    rd(`GPBK_OFF_STS, 32'h0004_0000);
    pins(32'h0000_0000);
    rd(`GPBK_OFF_STS, 32'h0006_0000);
    wr(`GPBK_OFF_STS, 32'h07FF_0000);
    rd(`GPBK_OFF_STS, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test edges done");

    wr(`GPBK_OFF_RISE, 32'h0008_0000);
    wr(`GPBK_OFF_DSET, 32'h0008_0000);
    rd(`GPBK_OFF_DIR, 32'h0008_0000);
    wr(`GPBK_OFF_SET, 32'h0008_0000);
    repeat (4) @(posedge pclk);
    rd(`GPBK_OFF_LEVEL, 32'h0008_0000);
    rd(`GPBK_OFF_STS, 32'h0000_0000);
    wr(`GPBK_OFF_DCLR, 32'h0008_0000);
    rd(`GPBK_OFF_DIR, 32'h0000_0000);
    chk(gpio_oe_n, 32'hFFFF_FFFF);
    $display("test output edge done");

    wr(`GPBK_OFF_DIR, 32'h07FF_0000);
    chk(gpio_oe_n, 32'hF800_FFFF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(gpio_oe_n, 32'hFFFF_FFFF);
    chk(gpio_out, 32'h0000_0000);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`GPBK_OFF_DIR, 32'h0000_0000);
    rd(`GPBK_OFF_RISE, 32'h0000_0000);
    $display("test mid reset done");
    complete_run;
  end
endmodule : tb

// >>> src/gpbk_cfg.svh
// gpio bank constants: register offsets, reset values, widths
// assumes a 32-bit apb slave with a 12-bit byte address
//
// Functional notes
// - eleven usable ports, each input or output, behind pin multiplexing
// - every reset makes every port an input until software changes it
// - pin direction register bits choose each port's direction
// - direction one means output, zero means input
// - output set writes drive ports high, output clear writes drive them low
// - ones in set or clear act, zeros leave the port level alone
// - set and clear work for inputs too and update stored output
// - stored output appears on the pin once the port becomes output
// - input ports detect rising, falling or both edges per enable bits
// - enabled edges are recorded in a readable edge status register
// - writing one clears a status bit, writing zero does nothing
// - recorded edges can raise an interrupt request
// - pin level register returns actual port state at any time
// - all registers are 32 bits, bit n is pin 64 plus n
`ifndef GPBK_CFG_SVH
`define GPBK_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define GPBK_DW        32
`define GPBK_AW        12
`define GPBK_PIN_BASE  64
`define GPBK_USE_LSB   16
`define GPBK_USE_MSB   26

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define GPBK_OFF_LEVEL 12'h008
`define GPBK_OFF_DIR   12'h014
`define GPBK_OFF_SET   12'h020
`define GPBK_OFF_CLR   12'h02C
`define GPBK_OFF_RISE  12'h038
`define GPBK_OFF_FALL  12'h044
`define GPBK_OFF_STS   12'h050
`define GPBK_OFF_MASK  12'h05C
`define GPBK_OFF_DSET  12'h408
`define GPBK_OFF_DCLR  12'h428

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPBK_RST_DIR   32'h0000_0000
`define GPBK_RST_OUT   32'h0000_0000
`define GPBK_RST_RISE  32'h0000_0000
`define GPBK_RST_FALL  32'h0000_0000
`define GPBK_RST_STS   32'h0000_0000
`define GPBK_RST_MASK  32'h0000_0000
`define GPBK_RST_PIN   32'h0000_0000

`endif

// >>> src/gpbk_edge.sv
// pin synchroniser and per-pin edge detector
// assumes pin inputs may change at any time relative to pclk
`timescale 1ns/1ps

module gpbk_edge
  import gpbk_pkg::*;
(
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // pins
  input  wire logic [`GPBK_DW-1:0] pin_in,
  // core side
  gpbk_edge_if.det    eif
);

  gpbk_word_t meta_reg;
  gpbk_word_t meta_next;
  gpbk_word_t sync_reg;
  gpbk_word_t sync_next;
  gpbk_word_t prev_reg;
  gpbk_word_t prev_next;

  // ----------------------------------------------------------------
  // synchroniser and history
  // ----------------------------------------------------------------
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= `GPBK_RST_PIN;
      sync_reg <= `GPBK_RST_PIN;
      prev_reg <= `GPBK_RST_PIN;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // ----------------------------------------------------------------
  // edge detection, inputs only
  // ----------------------------------------------------------------
  assign eif.level    = sync_reg;
  assign eif.edge_hit = ~eif.dir &
    ((sync_reg & ~prev_reg & eif.rise_en) |
     (~sync_reg & prev_reg & eif.fall_en));

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_edge_input_only;
    @(posedge pclk) disable iff (!presetn)
      (eif.edge_hit & eif.dir) == '0;
  endproperty
  a_edge_input_only: assert property (p_edge_input_only)
    else $error("edge reported on an output port");

  property p_edge_needs_change;
    @(posedge pclk) disable iff (!presetn)
      (eif.edge_hit != '0) |->
        ((eif.edge_hit & (sync_reg ^ prev_reg)) == eif.edge_hit);
  endproperty
  a_edge_needs_change: assert property (p_edge_needs_change)
    else $error("edge reported without a level change");

endmodule : gpbk_edge

// >>> src/gpbk_edge_if.sv
// carrier between the register core and the pin edge detector
// assumes both ends run on pclk
`timescale 1ns/1ps

interface gpbk_edge_if;
  import gpbk_pkg::*;
  gpbk_word_t dir;
  gpbk_word_t rise_en;
  gpbk_word_t fall_en;
  gpbk_word_t level;
  gpbk_word_t edge_hit;

  modport core (
    output dir,
    output rise_en,
    output fall_en,
    input  level,
    input  edge_hit
  );

  modport det (
    input  dir,
    input  rise_en,
    input  fall_en,
    output level,
    output edge_hit
  );
endinterface : gpbk_edge_if

// >>> src/gpbk_pkg.sv
// gpio bank types and the register decode function
// assumes gpbk_cfg.svh on the include path
`include "gpbk_cfg.svh"

package gpbk_pkg;

  typedef logic [`GPBK_DW-1:0] gpbk_word_t;
  typedef logic [`GPBK_AW-1:0] gpbk_addr_t;

  typedef enum logic [10:0] {
    GPBK_SEL_NONE  = 11'h001,
    GPBK_SEL_LEVEL = 11'h002,
    GPBK_SEL_DIR   = 11'h004,
    GPBK_SEL_SET   = 11'h008,
    GPBK_SEL_CLR   = 11'h010,
    GPBK_SEL_RISE  = 11'h020,
    GPBK_SEL_FALL  = 11'h040,
    GPBK_SEL_STS   = 11'h080,
    GPBK_SEL_MASK  = 11'h100,
    GPBK_SEL_DSET  = 11'h200,
    GPBK_SEL_DCLR  = 11'h400
  } gpbk_sel_t;

  // address to one-hot register select
  function automatic gpbk_sel_t gpbk_decode(input gpbk_addr_t addr);
    case (addr)
      `GPBK_OFF_LEVEL: gpbk_decode = GPBK_SEL_LEVEL;
      `GPBK_OFF_DIR:   gpbk_decode = GPBK_SEL_DIR;
      `GPBK_OFF_SET:   gpbk_decode = GPBK_SEL_SET;
      `GPBK_OFF_CLR:   gpbk_decode = GPBK_SEL_CLR;
      `GPBK_OFF_RISE:  gpbk_decode = GPBK_SEL_RISE;
      `GPBK_OFF_FALL:  gpbk_decode = GPBK_SEL_FALL;
      `GPBK_OFF_STS:   gpbk_decode = GPBK_SEL_STS;
      `GPBK_OFF_MASK:  gpbk_decode = GPBK_SEL_MASK;
      `GPBK_OFF_DSET:  gpbk_decode = GPBK_SEL_DSET;
      `GPBK_OFF_DCLR:  gpbk_decode = GPBK_SEL_DCLR;
      default:         gpbk_decode = GPBK_SEL_NONE;
    endcase
  endfunction : gpbk_decode

endpackage : gpbk_pkg

// >>> src/gpbk_top.sv
// gpio bank: apb register file, output drive, edge status, interrupt
// assumes a synchronous apb master on pclk; pins are plain in/out/oe_n
`timescale 1ns/1ps

module gpbk_top
  import gpbk_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic [`GPBK_AW-1:0] paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`GPBK_DW-1:0] pwdata,
  output logic      [`GPBK_DW-1:0] prdata,
  output logic                     pready,
  output logic                     pslverr,
  // pins, bit n is pin 64+n
  input  wire logic [`GPBK_DW-1:0] gpio_in,
  output logic      [`GPBK_DW-1:0] gpio_out,
  output logic      [`GPBK_DW-1:0] gpio_oe_n,
  // interrupt
  output logic                     irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  gpbk_word_t dir_reg;
  gpbk_word_t dir_next;
  gpbk_word_t oe_n_reg;
  gpbk_word_t oe_n_next;
  gpbk_word_t out_reg;
  gpbk_word_t out_next;
  gpbk_word_t rise_reg;
  gpbk_word_t rise_next;
  gpbk_word_t fall_reg;
  gpbk_word_t fall_next;
  gpbk_word_t sts_reg;
  gpbk_word_t sts_next;
  gpbk_word_t mask_reg;
  gpbk_word_t mask_next;
  logic       irq_reg;
  logic       irq_next;

  gpbk_word_t rdata_reg;
  gpbk_word_t rdata_next;
  logic       ready_reg;
  logic       ready_next;
  logic       err_reg;
  logic       err_next;

  gpbk_sel_t  sel;
  logic       setup;
  logic       wr_fire;
  gpbk_word_t sts_clr;

  // ----------------------------------------------------------------
  // edge detector
  // ----------------------------------------------------------------
  gpbk_edge_if eif ();

  assign eif.dir     = dir_reg;
  assign eif.rise_en = rise_reg;
  assign eif.fall_en = fall_reg;

  gpbk_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (gpio_in),
    .eif     (eif.det)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign sel     = gpbk_decode(paddr);
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & ready_reg & pwrite;

  // answer is ready in the first access cycle
  always_comb begin
    ready_next = setup;
    err_next   = setup & (sel == GPBK_SEL_NONE);
    rdata_next = rdata_reg;
    if (setup) begin
      case (sel)
        GPBK_SEL_LEVEL: rdata_next = eif.level;
        GPBK_SEL_DIR:   rdata_next = dir_reg;
        GPBK_SEL_RISE:  rdata_next = rise_reg;
        GPBK_SEL_FALL:  rdata_next = fall_reg;
        GPBK_SEL_STS:   rdata_next = sts_reg;
        GPBK_SEL_MASK:  rdata_next = mask_reg;
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ready_reg <= ready_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = ready_reg;
  assign pslverr = err_reg;

  // ----------------------------------------------------------------
  // direction and output drive
  // ----------------------------------------------------------------
  always_comb begin
    dir_next = dir_reg;
    out_next = out_reg;
    if (wr_fire) begin
      case (sel)
        GPBK_SEL_DIR:  dir_next = pwdata;
        GPBK_SEL_DSET: dir_next = dir_reg | pwdata;
        GPBK_SEL_DCLR: dir_next = dir_reg & ~pwdata;
        GPBK_SEL_SET:  out_next = out_reg | pwdata;
        GPBK_SEL_CLR:  out_next = out_reg & ~pwdata;
        default:       out_next = out_reg;
      endcase
    end
    oe_n_next = ~dir_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg  <= `GPBK_RST_DIR;
      oe_n_reg <= ~`GPBK_RST_DIR;
      out_reg  <= `GPBK_RST_OUT;
    end else begin
      dir_reg  <= dir_next;
      oe_n_reg <= oe_n_next;
      out_reg  <= out_next;
    end
  end

  // stored level always presented; the enable decides if it reaches the pin
  assign gpio_out  = out_reg;
  assign gpio_oe_n = oe_n_reg;

  // ----------------------------------------------------------------
  // edge enables and mask
  // ----------------------------------------------------------------
  always_comb begin
    rise_next = rise_reg;
    fall_next = fall_reg;
    mask_next = mask_reg;
    if (wr_fire) begin
      case (sel)
        GPBK_SEL_RISE: rise_next = pwdata;
        GPBK_SEL_FALL: fall_next = pwdata;
        GPBK_SEL_MASK: mask_next = pwdata;
        default:       mask_next = mask_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_reg <= `GPBK_RST_RISE;
      fall_reg <= `GPBK_RST_FALL;
      mask_reg <= `GPBK_RST_MASK;
    end else begin
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------------------------------
  // edge status and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    sts_clr = '0;
    if (wr_fire && sel == GPBK_SEL_STS) begin
      sts_clr = pwdata;
    end
    sts_next = (sts_reg & ~sts_clr) | eif.edge_hit;
    irq_next = |(sts_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= `GPBK_RST_STS;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_inputs;
    @(posedge pclk)
      $rose(presetn) |-> (gpio_oe_n == '1);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("ports not inputs after reset");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_DIR) |=>
        (gpio_oe_n == ~$past(pwdata));
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not reflected on enables");

  property p_set_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_SET) |=>
        ((gpio_out & $past(pwdata)) == $past(pwdata));
  endproperty
  a_set_write: assert property (p_set_write)
    else $error("output set did not drive high");

  property p_clr_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_CLR) |=>
        ((gpio_out & $past(pwdata)) == '0);
  endproperty
  a_clr_write: assert property (p_clr_write)
    else $error("output clear did not drive low");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && (sel == GPBK_SEL_SET || sel == GPBK_SEL_CLR)) |=>
        ((gpio_out & ~$past(pwdata)) == ($past(gpio_out) & ~$past(pwdata)));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("zero bit changed an output level");

  property p_out_while_input;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_SET && (dir_reg & pwdata) == '0) |=>
        ((gpio_out & $past(pwdata)) == $past(pwdata)) ##1
        (gpio_out == $past(gpio_out) || wr_fire);
  endproperty
  a_out_while_input: assert property (p_out_while_input)
    else $error("set on input port not stored");

  property p_edge_sets;
    @(posedge pclk) disable iff (!presetn)
      (eif.edge_hit != '0) |=>
        ((sts_reg & $past(eif.edge_hit)) == $past(eif.edge_hit));
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge lost in status");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_STS) |=>
        ((sts_reg & $past(pwdata) & ~$past(eif.edge_hit)) == '0) &&
        ((sts_reg & ~$past(pwdata)) == ($past(sts_reg) & ~$past(pwdata)));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status write one to clear broken");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == (|(sts_reg & mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow masked status");

  property p_level_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && sel == GPBK_SEL_LEVEL) |=>
        (prdata == $past(eif.level)) && pready;
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("pin level read mismatch");

  property p_ready_once;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 (!pready || (psel && !penable));
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("apb ready timing wrong");

  property p_dir_set_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_DSET) |=>
        (dir_reg == ($past(dir_reg) | $past(pwdata)));
  endproperty
  a_dir_set_write: assert property (p_dir_set_write)
    else $error("bitwise direction set broken");

  property p_dir_clr_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_fire && sel == GPBK_SEL_DCLR) |=>
        (dir_reg == ($past(dir_reg) & ~$past(pwdata)));
  endproperty
  a_dir_clr_write: assert property (p_dir_clr_write)
    else $error("bitwise direction clear broken");

  property p_oe_follows_dir;
    @(posedge pclk) disable iff (!presetn)
      gpio_oe_n == ~dir_reg;
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("output enable does not follow direction");

  property p_sts_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr_fire && sel == GPBK_SEL_STS) |=>
        ((sts_reg & $past(sts_reg)) == $past(sts_reg));
  endproperty
  a_sts_hold: assert property (p_sts_hold)
    else $error("status bit dropped without a clear");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_set_write: cover property (
    @(posedge pclk) disable iff (!presetn)
      wr_fire && sel == GPBK_SEL_SET);
  c_edge_seen: cover property (
    @(posedge pclk) disable iff (!presetn)
      eif.edge_hit != '0);
  c_irq_rise: cover property (
    @(posedge pclk) disable iff (!presetn)
      $rose(irq));
  c_clear_race: cover property (
    @(posedge pclk) disable iff (!presetn)
      wr_fire && sel == GPBK_SEL_STS && (eif.edge_hit & pwdata) != '0);
  c_dir_bitwise: cover property (
    @(posedge pclk) disable iff (!presetn)
      wr_fire && (sel == GPBK_SEL_DSET || sel == GPBK_SEL_DCLR));

endmodule : gpbk_top
